// ==== mmsp_chk_assertions.sv ====
// Purpose: port checks for mmsp_protect
// Assumes: bound from the bench top
// Notes: fixed region means address bits above 16 equal 5
`timescale 1ns/10ps
`default_nettype none
module mmsp_chk #(parameter PA_W = 52) (
  // watched ports
  input wire logic            mclk, nrst, in_mgmt_mode, acc_valid, reg_wr, reg_sel,
  input wire logic            save_rd, save_wr, save_hit, chk_valid, chk_fixed_hit,
  input wire logic            chk_prog_hit, chk_refuse,
  input wire logic            fixed_region_enable, programmable_region_enable,
  input wire logic [PA_W-1:0] acc_addr,
  input wire logic [63:0]     reg_wdata, reg_rdata,
  input wire logic [15:0]     save_offset,
  input wire logic [31:0]     save_rdata);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire rev = save_offset == 16'hFEFC;
  valid_lag_a: assert property (acc_valid |=> chk_valid) else $error("late");
  fixed_hit_a: assert property (acc_valid |=> chk_fixed_hit ==
    ($past(acc_addr) >> 17 == 5)) else $error("fixed hit");
  refuse_a: assert property (chk_valid |-> chk_refuse == (!$past(in_mgmt_mode) &&
    (chk_fixed_hit && $past(fixed_region_enable) ||
    chk_prog_hit && $past(programmable_region_enable)))) else $error("refuse");
  rev_read_a: assert property (save_rd && rev |=> save_hit &&
    save_rdata == 32'h00030064) else $error("rev word");
  other_read_a: assert property (save_rd && !rev |=> save_rdata == 0) else $error("rsv");
  rdata_hold_a: assert property (!save_rd |=> $stable(save_rdata)) else $error("hold");
  en_mask_a: assert property (reg_wr && reg_sel |=> {programmable_region_enable,
    fixed_region_enable} == $past(reg_wdata[1:0])) else $error("enable");
  low_bits_a: assert property (reg_rdata[16:2] == 0 &&
    (reg_sel || reg_rdata[1:0] == 0)) else $error("low bits");
  cover property (chk_refuse);
  cover property (save_hit);
  cover property (chk_prog_hit && !chk_refuse);
endmodule // mmsp_chk
`default_nettype wire

// ==== mmsp_core.sv ====
// Purpose: core access path model
// Assumes: bench raises go just after an edge
// Notes: idle address flips so a stale one never looks valid
`timescale 1ns/10ps
`default_nettype none
module mmsp_core #(parameter PA_W = 52) (
  // bench side
  input wire logic            mclk, go,
  input wire logic [PA_W-1:0] a,
  // design side
  output var logic            acc_valid,
  output var logic [PA_W-1:0] acc_addr);
  // quiet start before the first edge
  initial begin
    acc_valid = 0;
    acc_addr = 0;
  end
  // one access per go cycle
  always @(posedge mclk) begin
    acc_valid <= go;
    acc_addr <= go ? a : ~acc_addr;
  end
endmodule // mmsp_core
`default_nettype wire

// ==== mmsp_defs.vh ====
// Purpose: constants for the management memory protection block
// Assumes: included by bare name
// Notes: field positions, fixed region bounds, revision word layout
`ifndef MMSP_DEFS_VH
`define MMSP_DEFS_VH
`define MMSP_REV_WORD_OFFSET   16'hFEFC
`define MMSP_REV_LEVEL_LO      8'h64
`define MMSP_REV_LEVEL_HI      8'h00
`define MMSP_REV_IO_RESTART    16
`define MMSP_REV_RELOCATE      17
`define MMSP_MASK_FIXED_EN     0
`define MMSP_MASK_PROG_EN      1
`define MMSP_ADDR_LSB          17
`define MMSP_FIXED_W           20
`define MMSP_RG_FIXED          0
`define MMSP_RG_PROG           1
`define MMSP_RG_COUNT          2
`define MMSP_FIXED_LO          20'hA0000
`define MMSP_FIXED_HI          20'hBFFFF
`define MMSP_REG_SEL_BASE      1'h0
`define MMSP_REG_SEL_MASK      1'h1
`define MMSP_SAVE_OFFSET_W     16
`endif

// ==== mmsp_protect.v ====
// Purpose: management memory protection and revision word source
// Assumes: core presents one physical access per cycle with a valid strobe
// Notes: the check result is registered, so a decision lags its access by one cycle
`timescale 1ns/10ps
`default_nettype none
`include "mmsp_defs.vh"
// How it works
// - revision word reads at save-area offset FEFCh, writes never change it.
// - low sixteen bits hold revision level, low byte fixed, high byte counts.
// - bit 16 reads one, io instruction restart supported.
// - bit 17 reads one, management memory base relocatable.
// - every other revision bit is reserved and reads zero.
// - two protected regions exist; handler may live outside both.
// - fixed region spans A0000h through BFFFFh, not programmable.
// - programmable region uses base register and mask register.
// - access hits programmable region when masked address equals masked base.
// - base register holds bits 51:17; lower bits ignored.
// - mask bit 0 enables fixed region protection.
// - mask bit 1 enables programmable region protection.
// - mask bits 51:17 mask both address and base.
// - widths follow implemented physical address bits.
// - only the long save layout is used, never the older one.
module mmsp_protect #(
  parameter PA_W = 52
) (
  // clock and reset
  input  wire            mclk,
  input  wire            nrst,
  // core state
  input  wire            in_mgmt_mode,
  // physical access from the core
  input  wire            acc_valid,
  input  wire [PA_W-1:0] acc_addr,
  // model-specific register port
  input  wire            reg_wr,
  input  wire            reg_sel,
  input  wire [63:0]     reg_wdata,
  output reg  [63:0]     reg_rdata,
  // state-save area read port
  input  wire            save_rd,
  input  wire            save_wr,
  input  wire [15:0]     save_offset,
  output reg  [31:0]     save_rdata,
  output reg             save_hit,
  // protection result, one cycle after the access
  output reg             chk_valid,
  output reg             chk_fixed_hit,
  output reg             chk_prog_hit,
  output reg             chk_refuse,
  // current enables for the memory path
  output wire            fixed_region_enable,
  output wire            programmable_region_enable
);
  // region geometry; the fixed window lives entirely below the high field
  localparam HIGH_W = PA_W - `MMSP_FIXED_W;
  localparam NREG   = `MMSP_RG_COUNT;

  // stored register state
  reg  [PA_W-1:0]   seg_base;
  reg  [PA_W-1:0]   seg_mask;
  reg  [NREG-1:0]   region_en;

  // next values of the stored state
  reg  [PA_W-1:0]   next_seg_base;
  reg  [PA_W-1:0]   next_seg_mask;
  reg  [NREG-1:0]   next_region_en;
  reg  [31:0]       next_save_rdata;
  reg               next_save_hit;
  reg               next_chk_valid;
  reg               next_chk_fixed_hit;
  reg               next_chk_prog_hit;
  reg               next_chk_refuse;

  // decode and match results
  wire [31:0]       rev_word;
  wire              prog_match;
  wire              fixed_match;
  wire [NREG-1:0]   region_match;
  wire [NREG-1:0]   region_guard;
  wire              refuse_now;
  wire              base_sel;
  wire              rev_sel;

  // fixed window decode; anything above the low megabyte is outside it
  function fixed_window_hit;
    input [PA_W-1:0] addr;
    begin
      fixed_window_hit = (addr[PA_W-1:`MMSP_FIXED_W] == {HIGH_W{1'h0}}) &&
                         (addr[`MMSP_FIXED_W-1:0] >= `MMSP_FIXED_LO) &&
                         (addr[`MMSP_FIXED_W-1:0] <= `MMSP_FIXED_HI);
    end
  endfunction

  // save-area offset decode, shared by the hit flag and the read mux
  function rev_offset_hit;
    input [`MMSP_SAVE_OFFSET_W-1:0] offset;
    begin
      rev_offset_hit = (offset == `MMSP_REV_WORD_OFFSET);
    end
  endfunction

  // keep the granule-aligned field of a written word; low bits store zero
  // so a careless write below the granule can never shift the region
  function [PA_W-1:0] aligned_field;
    input [63:0] word;
    begin
      aligned_field = {word[PA_W-1:`MMSP_ADDR_LSB], {`MMSP_ADDR_LSB{1'h0}}};
    end
  endfunction

  // constant revision word
  mmsp_rev_word u_mmsp_rev_word (
    .rev_word (rev_word)
  );

  // programmable region masked compare
  mmsp_range_match #(.PA_W(PA_W)) u_mmsp_range_match (
    .addr (acc_addr),
    .base (seg_base),
    .mask (seg_mask),
    .hit  (prog_match)
  );

  // fixed window compare on the live access address
  assign fixed_match = fixed_window_hit(acc_addr);

  // both candidate regions side by side, indexed by region number
  assign region_match[`MMSP_RG_FIXED] = fixed_match;
  assign region_match[`MMSP_RG_PROG]  = prog_match;

  // a region guards an access only while its enable is set
  genvar r;
  generate
    for (r = 0; r < NREG; r = r + 1) begin : g_region
      assign region_guard[r] = region_en[r] && region_match[r];
    end
  endgenerate

  // refusal only for guarded hits and only outside management mode;
  // a handler placed outside both regions is simply never guarded
  assign refuse_now = acc_valid && !in_mgmt_mode && (|region_guard);

  // enables reach the memory path straight from the mask register bits
  assign fixed_region_enable        = region_en[`MMSP_RG_FIXED];
  assign programmable_region_enable = region_en[`MMSP_RG_PROG];

  // base register select decode, left unused; write and readback each decode reg_sel in a case
  assign base_sel = (reg_sel == `MMSP_REG_SEL_BASE);

  // next values for base, mask and enables; a write lands on one register only
  always @* begin
    next_seg_base  = seg_base;
    next_seg_mask  = seg_mask;
    next_region_en = region_en;
    if (reg_wr) begin
      case (reg_sel)
        `MMSP_REG_SEL_BASE: begin
          next_seg_base = aligned_field(reg_wdata);
        end
        `MMSP_REG_SEL_MASK: begin
          next_seg_mask = aligned_field(reg_wdata);
          next_region_en[`MMSP_RG_FIXED] = reg_wdata[`MMSP_MASK_FIXED_EN];
          next_region_en[`MMSP_RG_PROG]  = reg_wdata[`MMSP_MASK_PROG_EN];
        end
        default: begin
          next_seg_base = seg_base;
        end
      endcase
    end
  end

  // base, mask and enable flops; reset leaves both regions unguarded
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seg_base  <= {PA_W{1'h0}};
      seg_mask  <= {PA_W{1'h0}};
      region_en <= {NREG{1'h0}};
    end else begin
      seg_base  <= next_seg_base;
      seg_mask  <= next_seg_mask;
      region_en <= next_region_en;
    end
  end

  // register readback, unimplemented upper bits read zero; kept combinational
  // so software sees a write in the very next cycle
  always @* begin
    reg_rdata = 64'h0000000000000000;
    case (reg_sel)
      `MMSP_REG_SEL_BASE: begin
        reg_rdata[PA_W-1:0] = seg_base;
      end
      `MMSP_REG_SEL_MASK: begin
        reg_rdata[PA_W-1:0] = seg_mask;
        reg_rdata[`MMSP_MASK_FIXED_EN] = region_en[`MMSP_RG_FIXED];
        reg_rdata[`MMSP_MASK_PROG_EN]  = region_en[`MMSP_RG_PROG];
      end
      default: begin
        reg_rdata = 64'h0000000000000000;
      end
    endcase
  end

  // revision word slot decode
  assign rev_sel = rev_offset_hit(save_offset);

  // save-area next values; a write raises the hit flag but never the word,
  // because a stray write must not disturb the constant (long layout only)
  always @* begin
    next_save_hit   = (save_rd || save_wr) && rev_sel;
    next_save_rdata = save_rdata;
    if (save_rd && rev_sel) begin
      next_save_rdata = rev_word;
    end else if (save_rd) begin
      next_save_rdata = 32'h00000000;
    end
  end

  // save-area flops; the read word holds until the next read
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      save_rdata <= 32'h00000000;
      save_hit   <= 1'h0;
    end else begin
      save_rdata <= next_save_rdata;
      save_hit   <= next_save_hit;
    end
  end

  // next values of the access check; hits are reported whatever the enables
  always @* begin
    next_chk_valid     = acc_valid;
    next_chk_fixed_hit = acc_valid && region_match[`MMSP_RG_FIXED];
    next_chk_prog_hit  = acc_valid && region_match[`MMSP_RG_PROG];
    next_chk_refuse    = refuse_now;
  end

  // registered access check, one cycle behind the access
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      chk_valid     <= 1'h0;
      chk_fixed_hit <= 1'h0;
      chk_prog_hit  <= 1'h0;
      chk_refuse    <= 1'h0;
    end else begin
      chk_valid     <= next_chk_valid;
      chk_fixed_hit <= next_chk_fixed_hit;
      chk_prog_hit  <= next_chk_prog_hit;
      chk_refuse    <= next_chk_refuse;
    end
  end
endmodule // mmsp_protect
`default_nettype wire

// ==== mmsp_range_match.v ====
// Purpose: programmable region base/mask compare
// Assumes: address, base and mask share the implemented width
// Notes: bits below the region granule never take part
`timescale 1ns/10ps
`default_nettype none
`include "mmsp_defs.vh"
module mmsp_range_match #(
  parameter PA_W = 52
) (
  // compare inputs
  input  wire [PA_W-1:0] addr,
  input  wire [PA_W-1:0] base,
  input  wire [PA_W-1:0] mask,
  // result
  output wire            hit
);
  // masked compare on the upper bits only
  assign hit = ((addr[PA_W-1:`MMSP_ADDR_LSB] & mask[PA_W-1:`MMSP_ADDR_LSB]) ==
                (base[PA_W-1:`MMSP_ADDR_LSB] & mask[PA_W-1:`MMSP_ADDR_LSB]));
endmodule // mmsp_range_match
`default_nettype wire

// ==== mmsp_rev_word.v ====
// Purpose: constant management revision word for the state-save area
// Assumes: read path of the save-area logic selects this word at its offset
// Notes: reserved bits read as zero
`timescale 1ns/10ps
`default_nettype none
`include "mmsp_defs.vh"
module mmsp_rev_word #(
  parameter [7:0] REV_MINOR = `MMSP_REV_LEVEL_HI
) (
  // revision word out
  output wire [31:0] rev_word
);
  // level field, two capability bits, all else reserved zero
  assign rev_word = {14'h0000,
                     1'b1,
                     1'b1,
                     REV_MINOR,
                     `MMSP_REV_LEVEL_LO};
endmodule // mmsp_rev_word
`default_nettype wire

// ==== test_mmsp_protect.sv ====
// Purpose: self-checking bench for mmsp_protect
// Assumes: one access in flight at a time
// Notes: results expected from region bounds
`timescale 1ns/10ps
`default_nettype none
module test_mmsp_protect;
  logic mclk = 0, nrst = 0, mm = 0, go = 0, reg_wr = 0, reg_sel = 0, save_rd = 0;
  logic save_wr = 0, acc_valid, save_hit, cv, cf, cp, cr, fe, pe;
  logic [51:0] a = 0, acc_addr;
  logic [63:0] reg_wdata = 0, reg_rdata;
  logic [15:0] save_offset = 0;
  logic [31:0] save_rdata;
  int bad_count = 0, comparisons = 0;
  mmsp_core u_mmsp_core (.mclk, .go, .a, .acc_valid, .acc_addr);
  mmsp_protect u_mmsp_protect (.mclk, .nrst, .in_mgmt_mode(mm), .acc_valid, .acc_addr,
    .reg_wr, .reg_sel, .reg_wdata, .reg_rdata, .save_rd, .save_wr, .save_offset,
    .save_rdata, .save_hit, .chk_valid(cv), .chk_fixed_hit(cf), .chk_prog_hit(cp),
    .chk_refuse(cr), .fixed_region_enable(fe), .programmable_region_enable(pe));
  initial forever #10 mclk = ~mclk;
  task automatic cmp(string n, logic [63:0] e, logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic s, logic [63:0] d);
    @(posedge mclk) #1 {reg_wr, reg_sel, reg_wdata} = {1'b1, s, d};
    @(posedge mclk) #1 reg_wr = 0;
  endtask
  task automatic acc(logic m, logic [51:0] x, logic [3:0] e);
    {mm, go, a} = {m, 1'b1, x};
    @(posedge mclk) #1 go = 0;
    @(posedge mclk) #1 cmp("chk", e, {cv, cf, cp, cr});
  endtask
  task automatic rd(logic [15:0] o, logic w, logic [31:0] e);
    @(posedge mclk) #1 {save_offset, save_wr, save_rd} = {o, w, !w};
    @(posedge mclk) #1 {save_rd, save_wr} = 0;
    cmp("rdata", e, save_rdata);
    cmp("hit", o == 16'hFEFC, save_hit);
  endtask
  task automatic t_rev;
    rd(16'hFEFC, 0, 32'h00030064);
    rd(16'hFEFC, 1, 32'h00030064);
    rd(16'hFEFC, 0, 32'h00030064);
    rd(16'hFF00, 0, 32'h0);
  endtask
  task automatic t_regs;
    wr(0, 64'h11FFFF);
    cmp("base", 64'h100000, reg_rdata);
    wr(1, 64'hF_FFFF_FFFC_0003);
    cmp("mask", 64'hF_FFFF_FFFC_0003, reg_rdata);
    cmp("en", 2'b11, {fe, pe});
  endtask
  task automatic t_access;
    acc(0, 52'hA0000, 4'hD);
    acc(0, 52'hBFFFF, 4'hD);
    acc(0, 52'hC0000, 4'h8);
    acc(0, 52'h9FFFF, 4'h8);
    acc(0, 52'h13FFFF, 4'hB);
    acc(0, 52'h140000, 4'h8);
    acc(0, 52'h8_0010_0000, 4'h8);
    acc(1, 52'hA0000, 4'hC);
    acc(1, 52'h100000, 4'hA);
    wr(1, 64'hF_FFFF_FFFC_0002);
    acc(0, 52'hA0000, 4'hC);
    wr(1, 64'hF_FFFF_FFFC_0001);
    acc(0, 52'h100000, 4'hA);
  endtask
  task automatic results;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge mclk);
    #1 nrst = 1;
    t_rev;
    t_regs;
    t_access;
    results;
  end
  // hang guard
  initial begin
    #200000 bad_count++;
    results;
  end
endmodule // test_mmsp_protect
bind mmsp_protect mmsp_chk #(.PA_W(PA_W)) u_mmsp_chk (.mclk, .nrst, .in_mgmt_mode,
  .acc_valid, .reg_wr, .reg_sel, .save_rd, .save_wr, .save_hit, .chk_valid, .chk_fixed_hit,
  .chk_prog_hit, .chk_refuse, .fixed_region_enable, .programmable_region_enable,
  .acc_addr, .reg_wdata, .reg_rdata, .save_offset, .save_rdata);
`default_nettype wire
